// >>> rtl/fsm_monitor.sv
`default_nettype none
// Notes on behaviour
// - One 10-bit converter muxed over nine inputs, only while metrology enabled.
// - Every input measured once per 100 ms period, ground referenced.
// - Each result held in its own readable 16-bit register.
// - Ten live condition bits over two 8-bit bytes.
// - Live bits follow their conditions one clock later.
// - Rising edges latch into rise bytes, cleared by reading them.
// - Live and rise bytes sit at consecutive addresses.
// - Falling edges latch into fall bytes, cleared by reading them.
// - Warnings only update status; no autonomous action.
// - Seven warnings live in the first live, rise and fall bytes.
// - All warnings but die heat use programmable threshold and hysteresis.
// - Set above threshold plus hysteresis, clear below threshold minus hysteresis.
// - Masked warning becoming set pulls the active-low interrupt low.
// - Warning never asserts while threshold plus hysteresis exceeds 1022.
// - All thresholds reset to 1023, warnings inactive.
// - Die heat warning uses fixed limit, always enabled.
// - String overvoltage compares string voltage sample with its limits.
// - String overheat uses its own threshold on the string temperature.
// - Supply overcurrent warnings compare supply current samples.
// - Three faults in second bytes with the same capture behaviour.
// - Driver desaturation raises fault, disables driver until enable is cleared.
// - Converter desaturation raises fault and disables the converter.
// - Interrupt condition: any masked rise or fall capture bit set.
// - Level mode holds output low; pulse mode gives 10 us per new condition.
module fsm_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control bits
  input wire logic metrology_enable,
  input wire logic driver_enable,
  input wire logic converter_enable,
  input wire logic irq_pulse_select,
  // Converter interface
  output logic [3:0] adc_channel,
  output logic adc_start,
  input wire logic adc_done,
  input wire logic [fsm_pkg::ADC_W-1:0] adc_data,
  // Programmable limits
  input wire logic [fsm_pkg::ADC_W-1:0] string_heat_threshold,
  input wire logic [fsm_pkg::ADC_W-1:0] string_heat_hysteresis,
  input wire logic [fsm_pkg::ADC_W-1:0] string_overheat_threshold,
  input wire logic [fsm_pkg::ADC_W-1:0] string_overheat_hysteresis,
  input wire logic [fsm_pkg::ADC_W-1:0] string_overvoltage_threshold,
  input wire logic [fsm_pkg::ADC_W-1:0] string_overvoltage_hysteresis,
  input wire logic [fsm_pkg::ADC_W-1:0] string_undervoltage_threshold,
  input wire logic [fsm_pkg::ADC_W-1:0] string_undervoltage_hysteresis,
  input wire logic [fsm_pkg::ADC_W-1:0] supply_current_threshold,
  input wire logic [fsm_pkg::ADC_W-1:0] supply_current_hysteresis,
  input wire logic [fsm_pkg::ADC_W-1:0] aux_current_threshold,
  input wire logic [fsm_pkg::ADC_W-1:0] aux_current_hysteresis,
  // Analog fault comparators
  input wire logic die_heat_limit,
  input wire logic driver_desat_fault,
  input wire logic driver_overcurrent_fault,
  input wire logic converter_desat_fault,
  // Interrupt masks
  input wire logic [fsm_pkg::BYTE_W-1:0] warning_rise_mask,
  input wire logic [fsm_pkg::BYTE_W-1:0] fault_rise_mask,
  input wire logic [fsm_pkg::BYTE_W-1:0] warning_fall_mask,
  input wire logic [fsm_pkg::BYTE_W-1:0] fault_fall_mask,
  // Register read port
  input wire logic rd_stb,
  input wire logic [3:0] rd_addr,
  output logic [fsm_pkg::RES_W-1:0] rd_data,
  // Status bytes
  output logic [fsm_pkg::BYTE_W-1:0] warning_live_byte,
  output logic [fsm_pkg::BYTE_W-1:0] fault_live_byte,
  output logic [fsm_pkg::BYTE_W-1:0] warning_rise_byte,
  output logic [fsm_pkg::BYTE_W-1:0] fault_rise_byte,
  output logic [fsm_pkg::BYTE_W-1:0] warning_fall_byte,
  output logic [fsm_pkg::BYTE_W-1:0] fault_fall_byte,
  // Power block gates
  output logic driver_run,
  output logic converter_run,
  // Open-drain interrupt pin: o tied low, oe_n low pulls
  output logic irq_out_n_o,
  output logic irq_out_n_oe_n
);
  import fsm_pkg::*;

  // Status read addresses, live and rise consecutive
  localparam logic [3:0] A_WLIVE = 4'h9;
  localparam logic [3:0] A_WRISE = 4'hA;
  localparam logic [3:0] A_FLIVE = 4'hB;
  localparam logic [3:0] A_FRISE = 4'hC;
  localparam logic [3:0] A_WFALL = 4'hD;
  localparam logic [3:0] A_FFALL = 4'hE;

  fsm_seq_type state_reg;
  logic [PCNT_W-1:0] period_cnt_reg;
  logic period_tick;
  logic [3:0] chan_reg;
  logic [RES_W-1:0] result_reg [NUM_CH];
  logic [NUM_CH-1:0] sample_stb;
  logic [NUM_WARN-1:0] warn_cond;
  logic [NUM_ERR-1:0] err_cond;
  logic [BYTE_W-1:0] wlive_next;
  logic [BYTE_W-1:0] flive_next;
  logic [BYTE_W-1:0] wlive_reg;
  logic [BYTE_W-1:0] flive_reg;
  logic [BYTE_W-1:0] wrise_reg;
  logic [BYTE_W-1:0] frise_reg;
  logic [BYTE_W-1:0] wfall_reg;
  logic [BYTE_W-1:0] ffall_reg;
  logic rd_wrise;
  logic rd_frise;
  logic rd_wfall;
  logic rd_ffall;
  logic drv_lock_reg;
  logic cnv_lock_reg;
  logic irq_cond;
  logic irq_cond_reg;
  logic [ICNT_W-1:0] pulse_cnt_reg;
  logic irq_low_reg;
  logic [RES_W-1:0] rd_data_reg;

  // ----------------------------------------
  // Metrology sequencer
  // ----------------------------------------

  // Sampling period timer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      period_cnt_reg <= '0;
    end else if (!metrology_enable || period_tick) begin
      period_cnt_reg <= '0;
    end else begin
      period_cnt_reg <= period_cnt_reg + 1'b1;
    end
  end
  assign period_tick = metrology_enable && (period_cnt_reg == PCNT_W'(PERIOD_CYC - 1));

  // Walk the mux over every channel each period
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= FSM_IDLE;
      chan_reg <= '0;
    end else if (!metrology_enable) begin
      state_reg <= FSM_IDLE;
      chan_reg <= '0;
    end else begin
      unique case (state_reg)
        FSM_IDLE: begin
          if (period_tick) begin
            state_reg <= FSM_START;
            chan_reg <= CH_VBB;
          end
        end
        FSM_START: begin
          state_reg <= FSM_WAIT;
        end
        FSM_WAIT: begin
          if (adc_done) begin
            if (chan_reg == CH_LAST) begin
              state_reg <= FSM_IDLE;
            end else begin
              chan_reg <= chan_reg + 1'b1;
              state_reg <= FSM_START;
            end
          end
        end
      endcase
    end
  end

  // Converter request lines
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      adc_start <= 1'b0;
      adc_channel <= '0;
    end else begin
      adc_start <= metrology_enable && (state_reg == FSM_START);
      adc_channel <= chan_reg;
    end
  end

  // One result register per channel, code left aligned in 16 bits
  generate
    for (genvar i = 0; i < NUM_CH; i++) begin : g_res
      assign sample_stb[i] = (state_reg == FSM_WAIT) && adc_done && (chan_reg == 4'(i));
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          result_reg[i] <= '0;
        end else if (sample_stb[i]) begin
          result_reg[i] <= {adc_data, 6'h00};
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Warnings and faults
  // ----------------------------------------

  // Fixed limit comparator, cannot be masked off
  assign warn_cond[W_DIE] = die_heat_limit;
  // Programmable hysteresis comparators, no action beyond status
  fsm_hyst u_heat (.clk(clk), .sys_rst(sys_rst), .sample_stb(sample_stb[CH_STRING_TEMP]),
    .sample(adc_data), .threshold(string_heat_threshold),
    .hysteresis(string_heat_hysteresis), .warn(warn_cond[W_HEAT]));
  fsm_hyst u_ovht (.clk(clk), .sys_rst(sys_rst), .sample_stb(sample_stb[CH_STRING_TEMP]),
    .sample(adc_data), .threshold(string_overheat_threshold),
    .hysteresis(string_overheat_hysteresis), .warn(warn_cond[W_OVHT]));
  fsm_hyst u_ov (.clk(clk), .sys_rst(sys_rst), .sample_stb(sample_stb[CH_STRING_VOLT]),
    .sample(adc_data), .threshold(string_overvoltage_threshold),
    .hysteresis(string_overvoltage_hysteresis), .warn(warn_cond[W_OV]));
  fsm_hyst u_uv (.clk(clk), .sys_rst(sys_rst), .sample_stb(sample_stb[CH_STRING_VOLT]),
    .sample(~adc_data), .threshold(string_undervoltage_threshold),
    .hysteresis(string_undervoltage_hysteresis), .warn(warn_cond[W_UV]));
  fsm_hyst u_oc1 (.clk(clk), .sys_rst(sys_rst), .sample_stb(sample_stb[CH_IDD1]),
    .sample(adc_data), .threshold(supply_current_threshold),
    .hysteresis(supply_current_hysteresis), .warn(warn_cond[W_OC1]));
  fsm_hyst u_oc2 (.clk(clk), .sys_rst(sys_rst), .sample_stb(sample_stb[CH_IDD2]),
    .sample(adc_data), .threshold(aux_current_threshold),
    .hysteresis(aux_current_hysteresis), .warn(warn_cond[W_OC2]));

  assign err_cond[E_DESAT] = driver_desat_fault;
  assign err_cond[E_OC] = driver_overcurrent_fault;
  assign err_cond[E_CDESAT] = converter_desat_fault;

  // Live bytes, unused bits read zero
  assign wlive_next = {1'b0, warn_cond};
  assign flive_next = {5'h00, err_cond};

  // Live bytes registered once; immediate within a clock
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wlive_reg <= '0;
      flive_reg <= '0;
    end else begin
      wlive_reg <= wlive_next;
      flive_reg <= flive_next;
    end
  end

  // Clearing reads of the capture bytes
  assign rd_wrise = rd_stb && (rd_addr == A_WRISE);
  assign rd_frise = rd_stb && (rd_addr == A_FRISE);
  assign rd_wfall = rd_stb && (rd_addr == A_WFALL);
  assign rd_ffall = rd_stb && (rd_addr == A_FFALL);

  // Edge capture; a new edge wins over the clearing read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrise_reg <= '0;
      frise_reg <= '0;
      wfall_reg <= '0;
      ffall_reg <= '0;
    end else begin
      wrise_reg <= (rd_wrise ? '0 : wrise_reg) | (wlive_next & ~wlive_reg);
      frise_reg <= (rd_frise ? '0 : frise_reg) | (flive_next & ~flive_reg);
      wfall_reg <= (rd_wfall ? '0 : wfall_reg) | (~wlive_next & wlive_reg);
      ffall_reg <= (rd_ffall ? '0 : ffall_reg) | (~flive_next & flive_reg);
    end
  end

  // Register read mux, one cycle latency
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_reg <= '0;
    end else if (rd_stb) begin
      if (rd_addr <= CH_LAST) begin
        rd_data_reg <= result_reg[rd_addr];
      end else begin
        unique case (rd_addr)
          A_WLIVE: rd_data_reg <= {8'h00, wlive_reg};
          A_WRISE: rd_data_reg <= {8'h00, wrise_reg};
          A_FLIVE: rd_data_reg <= {8'h00, flive_reg};
          A_FRISE: rd_data_reg <= {8'h00, frise_reg};
          A_WFALL: rd_data_reg <= {8'h00, wfall_reg};
          A_FFALL: rd_data_reg <= {8'h00, ffall_reg};
          default: rd_data_reg <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Block shutdown on faults
  // ----------------------------------------

  // Lock held until software drops the enable
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      drv_lock_reg <= 1'b0;
      cnv_lock_reg <= 1'b0;
    end else begin
      if (driver_desat_fault || driver_overcurrent_fault) begin
        drv_lock_reg <= 1'b1;
      end else if (!driver_enable) begin
        drv_lock_reg <= 1'b0;
      end
      if (converter_desat_fault) begin
        cnv_lock_reg <= 1'b1;
      end else if (!converter_enable) begin
        cnv_lock_reg <= 1'b0;
      end
    end
  end

  // Run gates cut in the same edge the fault is seen
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      driver_run <= 1'b0;
      converter_run <= 1'b0;
    end else begin
      driver_run <= driver_enable && !drv_lock_reg && !driver_desat_fault
        && !driver_overcurrent_fault;
      converter_run <= converter_enable && !cnv_lock_reg && !converter_desat_fault;
    end
  end

  // ----------------------------------------
  // Interrupt pin
  // ----------------------------------------

  assign irq_cond = |(wrise_reg & warning_rise_mask) | |(frise_reg & fault_rise_mask)
    | |(wfall_reg & warning_fall_mask) | |(ffall_reg & fault_fall_mask);

  // Pulse length counter restarts on each new condition
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_cond_reg <= 1'b0;
      pulse_cnt_reg <= '0;
    end else begin
      irq_cond_reg <= irq_cond;
      if (irq_cond && !irq_cond_reg) begin
        pulse_cnt_reg <= ICNT_W'(PULSE_CYC);
      end else if (pulse_cnt_reg != '0) begin
        pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
      end
    end
  end

  // Level or pulse drive of the pin
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_low_reg <= 1'b0;
    end else if (irq_pulse_select) begin
      irq_low_reg <= (irq_cond && !irq_cond_reg) || (pulse_cnt_reg > 1);
    end else begin
      irq_low_reg <= irq_cond;
    end
  end

  assign irq_out_n_o = 1'b0;
  assign irq_out_n_oe_n = !irq_low_reg;
  assign rd_data = rd_data_reg;
  assign warning_live_byte = wlive_reg;
  assign fault_live_byte = flive_reg;
  assign warning_rise_byte = wrise_reg;
  assign fault_rise_byte = frise_reg;
  assign warning_fall_byte = wfall_reg;
  assign fault_fall_byte = ffall_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_new_fault;
    driver_desat_fault;
  endsequence
  a_driver_off: assert property (@(posedge clk) disable iff (sys_rst)
    s_new_fault |=> !driver_run [*2]) else $error("driver ran after fault");
  a_conv_off: assert property (@(posedge clk) disable iff (sys_rst)
    converter_desat_fault |=> !converter_run) else $error("converter ran after fault");
  a_rise_keep: assert property (@(posedge clk) disable iff (sys_rst)
    (rd_wrise && wlive_next[W_DIE] && !wlive_reg[W_DIE]) |=> wrise_reg[W_DIE])
    else $error("rise lost on read");
  a_rise_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (rd_wrise && (wlive_next == wlive_reg)) |=> wrise_reg == '0)
    else $error("rise not cleared");
  a_fall_cap: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(flive_reg[E_DESAT]) |-> ffall_reg[E_DESAT]) else $error("fall missed");
  a_live_follow: assert property (@(posedge clk) disable iff (sys_rst)
    driver_overcurrent_fault |=> flive_reg[E_OC]) else $error("live bit lagging");
  a_level_irq: assert property (@(posedge clk) disable iff (sys_rst)
    (!irq_pulse_select && irq_cond) |=> !irq_out_n_oe_n) else $error("level irq missing");
  a_no_run_idle: assert property (@(posedge clk) disable iff (sys_rst)
    !metrology_enable |=> !adc_start) else $error("conversion while disabled");
  a_pulse_start: assert property (@(posedge clk) disable iff (sys_rst)
    (irq_pulse_select && irq_cond && !irq_cond_reg) |=> !irq_out_n_oe_n [*8])
    else $error("pulse too short");
endmodule : fsm_monitor
`default_nettype wire

// >>> rtl/fsm_pkg.sv
`default_nettype none
package fsm_pkg;
  // Converter and sample widths
  localparam int ADC_W = 10;
  localparam int RES_W = 16;
  localparam int THR_W = 11;
  localparam int NUM_CH = 9;
  localparam int NUM_WARN = 7;
  localparam int NUM_ERR = 3;
  localparam int BYTE_W = 8;

  // Channel order in the conversion sequence
  localparam logic [3:0] CH_VBB = 4'h0;
  localparam logic [3:0] CH_VDD1 = 4'h1;
  localparam logic [3:0] CH_VDD2 = 4'h2;
  localparam logic [3:0] CH_STRING_VOLT = 4'h3;
  localparam logic [3:0] CH_ILED = 4'h4;
  localparam logic [3:0] CH_IBB = 4'h5;
  localparam logic [3:0] CH_IDD1 = 4'h6;
  localparam logic [3:0] CH_IDD2 = 4'h7;
  localparam logic [3:0] CH_STRING_TEMP = 4'h8;
  localparam logic [3:0] CH_LAST = 4'h8;

  // Warning bit positions in the warning bytes
  localparam int W_DIE = 0;
  localparam int W_HEAT = 1;
  localparam int W_OVHT = 2;
  localparam int W_OV = 3;
  localparam int W_UV = 4;
  localparam int W_OC1 = 5;
  localparam int W_OC2 = 6;
  // Fault bit positions in the fault bytes
  localparam int E_DESAT = 0;
  localparam int E_OC = 1;
  localparam int E_CDESAT = 2;

  // Threshold reset value and disable limit
  localparam logic [ADC_W-1:0] THR_RESET = 10'h3FF;
  localparam logic [THR_W-1:0] THR_LIMIT = 11'h3FE;

  // Timing
  localparam longint CLK_HZ = 200000000;
  localparam longint PERIOD_MS = 100;
  localparam longint PERIOD_CYC = CLK_HZ / 1000 * PERIOD_MS;
  localparam longint PULSE_US = 10;
  localparam longint PULSE_CYC = CLK_HZ / 1000000 * PULSE_US;
  localparam int PCNT_W = 25;
  localparam int ICNT_W = 12;

  typedef enum logic [1:0] {
    FSM_IDLE,
    FSM_START,
    FSM_WAIT
  } fsm_seq_type;
endpackage : fsm_pkg
`default_nettype wire

// >>> rtl/fsm_hyst.sv
`default_nettype none
// ----------------------------------------
// Hysteresis comparator for one warning
// ----------------------------------------
module fsm_hyst (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Sample and limits
  input wire logic sample_stb,
  input wire logic [fsm_pkg::ADC_W-1:0] sample,
  input wire logic [fsm_pkg::ADC_W-1:0] threshold,
  input wire logic [fsm_pkg::ADC_W-1:0] hysteresis,
  // Warning level
  output logic warn
);
  import fsm_pkg::*;
  logic [THR_W-1:0] upper;
  logic [THR_W-1:0] lower;
  logic disabled;
  logic warn_reg;

  // Upper and lower trip points, lower floors at zero
  assign upper = THR_W'(threshold) + THR_W'(hysteresis);
  assign lower = (hysteresis > threshold) ? '0 : THR_W'(threshold) - THR_W'(hysteresis);
  assign disabled = upper > THR_LIMIT;

  // Set above upper, clear below lower, hold between
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      warn_reg <= 1'b0;
    end else if (disabled) begin
      warn_reg <= 1'b0;
    end else if (sample_stb) begin
      if (THR_W'(sample) > upper) begin
        warn_reg <= 1'b1;
      end else if (THR_W'(sample) < lower) begin
        warn_reg <= 1'b0;
      end
    end
  end
  assign warn = warn_reg;

  a_disabled_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    $past(disabled) |-> !warn_reg) else $error("warning set while disabled");
  // A threshold left at its reset value lands above the limit, so the warning stays off
  a_reset_thr_off: assert property (@(posedge clk) disable iff (sys_rst)
    (threshold == THR_RESET) |=> !warn_reg) else $error("warning on reset threshold");
endmodule : fsm_hyst
`default_nettype wire

// >>> sim/fsm_adc_model.sv
`default_nettype none
// ----------------------------------------
// Converter model on the far side
// ----------------------------------------
module fsm_adc_model (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Conversion request
  input wire logic adc_start,
  input wire logic [3:0] adc_channel,
  // Conversion answer
  output logic adc_done,
  output logic [fsm_pkg::ADC_W-1:0] adc_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import fsm_pkg::*;
  int cnt;
  logic [3:0] ch;
  // Slow answer; data flips while idle so a stale value never looks valid
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 0;
      ch <= 4'h0;
      adc_done <= 1'b0;
      adc_data <= 10'h155;
    end else begin
      adc_done <= (cnt == 1);
      adc_data <= (cnt == 1) ? {ch, 6'h2A} : ~adc_data;
      if (adc_start) begin
        cnt <= 7;
        ch <= adc_channel;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : fsm_adc_model
`default_nettype wire

// >>> sim/fault_status_monitor_tb_top.sv
`default_nettype none
// ----------------------------------------
// Status monitor bench
// ----------------------------------------
module fault_status_monitor_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fsm_pkg::*;
  localparam logic [7:0] DB = 8'(1 << W_DIE);
  localparam logic [7:0] EB = 8'((1 << E_DESAT) | (1 << E_OC) | (1 << E_CDESAT));
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic me = 1'b0, de = 1'b0, ce = 1'b0, ips = 1'b0, rs = 1'b0;
  logic die = 1'b0, dd = 1'b0, doc = 1'b0, cd = 1'b0;
  logic [ADC_W-1:0] thr = THR_RESET, hys = 10'h000;
  logic [7:0] wrm = 8'h00, frm = 8'h00, wfm = 8'h00, ffm = 8'h00;
  logic [3:0] ra = 4'h0, ach;
  logic ast, adn, drun, crun, io, ioe;
  logic [ADC_W-1:0] ad;
  logic [RES_W-1:0] rdd, v;
  logic [7:0] wl, fl, wr, fr, wf, ff;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  int conv_cnt = 0;
  // Clock and cycle ceiling; the longest scenario is the irq pulse
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ast) begin
      conv_cnt <= conv_cnt + 1;
    end
    if (cyc == 20000) begin
      err_total = err_total + 1;
      end_sim();
    end
  end
  fsm_monitor u_fsm_monitor (
    .clk(clk), .sys_rst(rst), .metrology_enable(me), .driver_enable(de),
    .converter_enable(ce), .irq_pulse_select(ips), .adc_channel(ach),
    .adc_start(ast), .adc_done(adn), .adc_data(ad),
    .string_heat_threshold(thr), .string_heat_hysteresis(hys),
    .string_overheat_threshold(thr), .string_overheat_hysteresis(hys),
    .string_overvoltage_threshold(thr), .string_overvoltage_hysteresis(hys),
    .string_undervoltage_threshold(thr), .string_undervoltage_hysteresis(hys),
    .supply_current_threshold(thr), .supply_current_hysteresis(hys),
    .aux_current_threshold(thr), .aux_current_hysteresis(hys),
    .die_heat_limit(die), .driver_desat_fault(dd), .driver_overcurrent_fault(doc),
    .converter_desat_fault(cd), .warning_rise_mask(wrm), .fault_rise_mask(frm),
    .warning_fall_mask(wfm), .fault_fall_mask(ffm), .rd_stb(rs), .rd_addr(ra),
    .rd_data(rdd), .warning_live_byte(wl), .fault_live_byte(fl),
    .warning_rise_byte(wr), .fault_rise_byte(fr), .warning_fall_byte(wf),
    .fault_fall_byte(ff), .driver_run(drun), .converter_run(crun),
    .irq_out_n_o(io), .irq_out_n_oe_n(ioe)
  );
  fsm_adc_model u_fsm_adc_model (
    .clk(clk), .sys_rst(rst), .adc_start(ast), .adc_channel(ach),
    .adc_done(adn), .adc_data(ad)
  );
  task automatic end_sim();
    if (err_total == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Cycle step; ends just past the edge so later drives stay off it
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tk
  // One register read: strobe taken at the first edge, data a cycle later
  task automatic rd(input logic [3:0] a);
    rs <= 1'b1;
    ra <= a;
    @(posedge clk);
    rs <= 1'b0;
    tk(1);
    v = rdd;
  endtask : rd
  task automatic t_reads();
    for (int a = 0; a < 16; a++) begin
      rd(4'(a));
      chk("read after reset", v, 16'h0000);
    end
    chk("warnings idle", 16'(wl), 16'h0000);
  endtask : t_reads
  task automatic t_warn();
    die <= 1'b1;
    tk(3);
    chk("live die heat", 16'(wl), 16'(DB));
    chk("rise die heat", 16'(wr), 16'(DB));
    chk("driver untouched", 16'(drun), 16'h0001);
    rd(4'h9);
    chk("read live", v, 16'(DB));
    rd(4'hA);
    chk("read rise", v, 16'(DB));
    chk("rise cleared", 16'(wr), 16'h0000);
    die <= 1'b0;
    tk(3);
    chk("live gone", 16'(wl), 16'h0000);
    chk("fall die heat", 16'(wf), 16'(DB));
    rd(4'hD);
    chk("read fall", v, 16'(DB));
    chk("fall cleared", 16'(wf), 16'h0000);
  endtask : t_warn
  // Edge lands on the very edge of the clearing read
  task automatic t_race();
    die <= 1'b1;
    rd(4'hA);
    chk("race read old rise", v, 16'h0000);
    chk("rise survives read", 16'(wr), 16'(DB));
    rd(4'hA);
    chk("race rise read", v, 16'(DB));
    die <= 1'b0;
    tk(3);
    rd(4'hD);
    chk("race fall read", v, 16'(DB));
  endtask : t_race
  task automatic t_irq_level();
    wrm <= DB;
    tk(3);
    chk("irq idle", 16'(ioe), 16'h0001);
    die <= 1'b1;
    tk(4);
    chk("irq on rise", 16'(ioe), 16'h0000);
    tk(20);
    chk("irq level holds", 16'(ioe), 16'h0000);
    rd(4'hA);
    tk(2);
    chk("irq released", 16'(ioe), 16'h0001);
    die <= 1'b0;
    tk(4);
    chk("fall unmasked", 16'(ioe), 16'h0001);
    wfm <= DB;
    tk(3);
    chk("fall masked in", 16'(ioe), 16'h0000);
    rd(4'hD);
    tk(2);
    chk("irq after fall read", 16'(ioe), 16'h0001);
    chk("pin drive level", 16'(io), 16'h0000);
    wfm <= 8'h00;
  endtask : t_irq_level
  task automatic t_irq_pulse();
    ips <= 1'b1;
    die <= 1'b1;
    tk(4);
    chk("pulse starts", 16'(ioe), 16'h0000);
    tk(1000);
    chk("pulse midway", 16'(ioe), 16'h0000);
    tk(996);
    chk("pulse lasts 10 us", 16'(ioe), 16'h0000);
    tk(4);
    chk("pulse ends", 16'(ioe), 16'h0001);
    rd(4'hA);
    die <= 1'b0;
    tk(3);
    rd(4'hD);
    ips <= 1'b0;
  endtask : t_irq_pulse
  task automatic t_faults();
    chk("driver runs", 16'(drun), 16'h0001);
    frm <= EB;
    dd <= 1'b1;
    tk(1);
    dd <= 1'b0;
    tk(3);
    chk("desat stops driver", 16'(drun), 16'h0000);
    chk("fault irq", 16'(ioe), 16'h0000);
    tk(10);
    chk("driver stays off", 16'(drun), 16'h0000);
    de <= 1'b0;
    tk(2);
    de <= 1'b1;
    tk(3);
    chk("driver restart", 16'(drun), 16'h0001);
    doc <= 1'b1;
    tk(3);
    chk("overcurrent live", 16'(fl), 16'(8'(1 << E_OC)));
    chk("converter runs", 16'(crun), 16'h0001);
    doc <= 1'b0;
    cd <= 1'b1;
    tk(3);
    chk("converter live", 16'(fl), 16'(8'(1 << E_CDESAT)));
    chk("converter off", 16'(crun), 16'h0000);
    cd <= 1'b0;
    tk(3);
    chk("converter stays off", 16'(crun), 16'h0000);
    rd(4'hC);
    chk("fault rise read", v, 16'(EB));
    chk("fault irq cleared", 16'(ioe), 16'h0001);
    rd(4'hE);
    chk("fault fall read", v, 16'(EB));
    chk("fault rise clear", 16'(fr), 16'h0000);
    frm <= 8'h00;
    ce <= 1'b0;
    tk(2);
    ce <= 1'b1;
    tk(3);
    chk("converter restart", 16'(crun), 16'h0001);
  endtask : t_faults
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    #1;
    chk("irq off in reset", 16'(ioe), 16'h0001);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    tk(2);
    t_reads();
    me <= 1'b1;
    de <= 1'b1;
    ce <= 1'b1;
    tk(4);
    t_warn();
    t_race();
    t_irq_level();
    t_irq_pulse();
    t_faults();
    chk("no conversion inside period", 16'(conv_cnt), 16'h0000);
    end_sim();
  end
endmodule : fault_status_monitor_tb_top
`default_nettype wire
